/* act_core.sv */
/*
  act_core: sample clock and run control, timestamp, aperture store decision, capture memory
  and trigger routing, reached over AHB-Lite.
  Assumes all pins synchronous to i_mclk, a 14-bit converter answering o_adc_convert with
  i_adc_done, and a carrier that acknowledges interrupts with i_irq_ack.
*/
module act_core
  import act_pkg::*;
#(
  parameter int FIFO_AW = FIFO_AW_DEF
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_osc_1mhz,
  input wire logic [1:0] i_fp_in,
  output logic [1:0] o_fp_out,
  input wire logic [1:0] i_backplane_trigger_pair,
  output logic [1:0] o_backplane_trigger_pair,
  output logic [1:0] o_backplane_trigger_pair_oe_n,
  input wire logic i_aperture_sel,
  output logic o_adc_convert,
  input wire logic i_adc_done,
  input wire logic [13:0] i_adc_data,
  output logic o_irq_n,
  input wire logic i_irq_ack,
  output logic [7:0] o_irq_vector
);

  localparam logic [FIFO_AW:0] DEPTH = (FIFO_AW + 1)'(1) << FIFO_AW;

  function automatic logic pick(input logic [2:0] sel, input logic [4:0] vec);
    return (sel <= SRC_BPB) ? vec[sel] : 1'b0;
  endfunction

  // bus side
  logic wen_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [31:0] rdata_w;

  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire rd_go = addr_ok & ~i_hwrite;
  wire [7:0] raddr_w = {i_haddr[7:2], 2'b00};
  wire wr_ctrl = wen_q & (waddr_q == OFS_CTRL);
  wire wr_src = wen_q & (waddr_q == OFS_SRC);
  wire wr_presc = wen_q & (waddr_q == OFS_PRESC);
  wire wr_omap = wen_q & (waddr_q == OFS_OMAP);
  wire wr_inctl = wen_q & (waddr_q == OFS_INCTL);
  wire wr_apa = wen_q & (waddr_q == OFS_APA);
  wire wr_apb = wen_q & (waddr_q == OFS_APB);
  wire wr_raddr = wen_q & (waddr_q == OFS_RADDR);
  wire wr_irq = wen_q & (waddr_q == OFS_IRQ);
  wire wr_status = wen_q & (waddr_q == OFS_STATUS);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wen_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      wen_q <= addr_ok & i_hwrite;
      waddr_q <= raddr_w;
      hrdata_q <= rd_go ? rdata_w : 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
  end

  // software registers
  act_ctrl_s ctrl_q;
  logic [7:0] src_q;
  logic [16:0] presc_q;
  logic [17:0] omap_q;
  logic [3:0] inctl_q;
  logic [31:0] apa_q;
  logic [31:0] apb_q;
  logic irq_en_q;
  logic [7:0] vec_q;

  wire act_ctrl_s wctl = act_ctrl_s'(i_hwdata);
  wire [16:0] pw = i_hwdata[16:0];
  // upper bits count too, so an oversized value clamps high instead of wrapping
  wire presc_big = (|i_hwdata[31:PRESC_W]) | (pw > PRESC_MAX);
  wire [16:0] presc_d = presc_big ? PRESC_MAX : ((pw < PRESC_MIN) ? PRESC_MIN : pw);
  wire ts_clr_w = (wr_ctrl & wctl.ts_clr) | (wr_ctrl & wctl.ts_clr_on_en & wctl.ace & ~ctrl_q.ace);
  wire fifo_clr_w = wr_ctrl & wctl.fifo_rst;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ctrl_q <= CTRL_RST;
      src_q <= SRC_RST;
      presc_q <= PRESC_RST;
      omap_q <= OMAP_RST;
      inctl_q <= INCTL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {wctl.rsvd & 23'h000000, wctl.ap_mode, 2'b00, wctl[4:0]};
      end
      if (wr_src) begin
        src_q <= i_hwdata[7:0];
      end
      if (wr_presc) begin
        presc_q <= presc_d;
      end
      if (wr_omap) begin
        omap_q <= i_hwdata[17:0];
      end
      if (wr_inctl) begin
        inctl_q <= i_hwdata[3:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      apa_q <= AP_RST;
      apb_q <= AP_RST;
      irq_en_q <= 1'b0;
      vec_q <= VEC_RST;
    end else begin
      if (wr_apa) begin
        apa_q <= i_hwdata;
      end
      if (wr_apb) begin
        apb_q <= i_hwdata;
      end
      if (wr_irq) begin
        irq_en_q <= i_hwdata[IRQ_EN_BIT];
        vec_q <= i_hwdata[IRQ_VEC_LSB +: 8];
      end
    end
  end

  // front panel inputs: inversion then optional arm latch
  logic [1:0] fp_prev_q;
  logic [1:0] fp_lat_q;
  logic [1:0] fp_eff;

  for (genvar k = 0; k < 2; k++) begin : g_fp
    wire lvl = i_fp_in[k] ^ inctl_q[k];
    wire rise = lvl & ~fp_prev_q[k];
    wire rearm = wr_inctl & i_hwdata[INCTL_REARM_LSB + k];
    always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
        fp_prev_q[k] <= 1'b0;
        fp_lat_q[k] <= 1'b0;
      end else begin
        fp_prev_q[k] <= lvl;
        // a trigger edge landing on the re-arm write still counts
        fp_lat_q[k] <= (rise & inctl_q[2 + k]) | (fp_lat_q[k] & ~rearm);
      end
    end
    assign fp_eff[k] = inctl_q[2 + k] ? fp_lat_q[k] : lvl;
  end

  // source selection and prescaler
  wire [4:0] clk_vec = {i_backplane_trigger_pair, fp_eff, i_osc_1mhz};
  wire [4:0] run_vec = {i_backplane_trigger_pair, fp_eff, ctrl_q.run};
  wire clk_lvl = pick(src_q[2:0], clk_vec);
  wire run_lvl = pick(src_q[6:4], run_vec);

  logic clk_prev_q;
  logic [16:0] pcnt_q;
  logic tick_q;
  wire clk_edge = clk_lvl & ~clk_prev_q;
  wire pcnt_wrap = (pcnt_q >= presc_q - PRESC_MIN);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      clk_prev_q <= 1'b0;
      pcnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_lvl;
      tick_q <= clk_edge & pcnt_wrap;
      if (clk_edge) begin
        pcnt_q <= pcnt_wrap ? 17'h00000 : pcnt_q + 17'h00001;
      end
    end
  end

  // timestamp
  logic [31:0] ts_q;
  logic roll_q;
  wire ts_inc = tick_q & run_lvl & (ctrl_q.ace | ctrl_q.ts_free);
  wire ts_wrap = ts_inc & (ts_q == 32'hffff_ffff);
  wire roll_clr = i_irq_ack | (wr_irq & i_hwdata[IRQ_FLAG_BIT]);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ts_q <= 32'h0000_0000;
      roll_q <= 1'b0;
    end else begin
      if (ts_clr_w) begin
        ts_q <= 32'h0000_0000;
      end else if (ts_inc) begin
        ts_q <= ts_q + 32'h0000_0001;
      end
      roll_q <= ts_wrap | (roll_q & ~roll_clr);
    end
  end

  // interrupt line, released by acknowledge
  logic irq_n_q;
  logic [7:0] irq_vec_q;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      irq_n_q <= 1'b1;
      irq_vec_q <= VEC_RST;
    end else begin
      irq_n_q <= ~(roll_q & irq_en_q & ~roll_clr);
      irq_vec_q <= vec_q;
    end
  end

  // conversion and aperture decision
  logic conv_q;
  logic [13:0] cur_q;
  logic [13:0] last_q;
  logic have_last_q;
  logic ap_b_q;
  logic store_q;

  wire conv_now = tick_q & run_lvl & ctrl_q.ace;
  wire use_b = (ctrl_q.ap_mode == AP_EXT) ? i_aperture_sel : ((ctrl_q.ap_mode == AP_AUTO) & ap_b_q);
  wire [31:0] ap_w = use_b ? apb_q : apa_q;
  wire [17:0] diff_w = {{4{i_adc_data[13]}}, i_adc_data} - {{4{last_q[13]}}, last_q};
  wire [17:0] ndiff_w = 18'h00000 - diff_w;
  wire over_w = $signed(diff_w) > $signed({2'b00, ap_w[31:16]});
  wire under_w = $signed(ndiff_w) > $signed({2'b00, ap_w[15:0]});
  wire keep_w = (ctrl_q.ap_mode == AP_OFF) | ~have_last_q | over_w | under_w;
  wire store_w = i_adc_done & ctrl_q.ace & keep_w;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      conv_q <= 1'b0;
      cur_q <= 14'h0000;
      last_q <= 14'h0000;
      have_last_q <= 1'b0;
      ap_b_q <= 1'b0;
      store_q <= 1'b0;
    end else begin
      conv_q <= conv_now;
      store_q <= store_w;
      if (i_adc_done) begin
        cur_q <= i_adc_data;
      end
      if (store_w) begin
        last_q <= i_adc_data;
      end
      // auto mode restarts on aperture a with each run
      ap_b_q <= ctrl_q.ace & (ap_b_q ^ (store_w & (ctrl_q.ap_mode == AP_AUTO)));
      // a fresh run starts without a reference value
      have_last_q <= (have_last_q | store_w) & ctrl_q.ace & ~fifo_clr_w;
    end
  end

  // capture memory
  logic [31:0] mem [0:(1 << FIFO_AW) - 1];
  logic [FIFO_AW:0] wr_ptr_q;
  logic [FIFO_AW:0] rd_ptr_q;
  logic ovf_q;
  act_wr_e wst_q;
  logic [15:0] word2_q;

  wire [FIFO_AW:0] count_w = wr_ptr_q - rd_ptr_q;
  wire empty_w = (count_w == '0);
  wire full_w = (count_w == DEPTH);
  wire room_w = ctrl_q.pair ? (count_w <= DEPTH - (FIFO_AW + 1)'(2)) : ~full_w;
  wire [15:0] val16 = {{2{i_adc_data[13]}}, i_adc_data};
  wire act_entry_s entry_w = '{value: val16, stamp: ts_q};
  wire put_first = store_w & room_w & (wst_q == WR_IDLE);
  wire put_second = (wst_q == WR_SECOND);
  wire mem_we = put_first | put_second;
  wire [31:0] mem_wd = put_second ? {word2_q, 16'h0000} :
    (ctrl_q.pair ? entry_w[47:16] : {entry_w.value, 16'h0000});
  wire [31:0] mem_rd = mem[rd_ptr_q[FIFO_AW-1:0]];
  wire pop_w = rd_go & (raddr_w == OFS_FIFO) & ~empty_w;
  wire [FIFO_AW-1:0] seek_w = i_hwdata[FIFO_AW-1:0];
  wire seek_lap = (seek_w <= wr_ptr_q[FIFO_AW-1:0]) ? wr_ptr_q[FIFO_AW] : ~wr_ptr_q[FIFO_AW];

  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[wr_ptr_q[FIFO_AW-1:0]] <= mem_wd;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wst_q <= WR_IDLE;
      word2_q <= 16'h0000;
    end else begin
      case (wst_q)
        WR_IDLE: begin
          if (put_first & ctrl_q.pair) begin
            wst_q <= WR_SECOND;
            word2_q <= entry_w[15:0];
          end
        end
        WR_SECOND: begin
          wst_q <= WR_IDLE;
        end
        default: begin
          wst_q <= WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (fifo_clr_w) begin
        wr_ptr_q <= '0;
      end else if (mem_we) begin
        wr_ptr_q <= wr_ptr_q + (FIFO_AW + 1)'(1);
      end
      if (fifo_clr_w) begin
        rd_ptr_q <= '0;
      end else if (wr_raddr) begin
        rd_ptr_q <= {seek_lap, seek_w};
      end else if (pop_w) begin
        rd_ptr_q <= rd_ptr_q + (FIFO_AW + 1)'(1);
      end
      // a lost sample is reported even on the clearing write
      ovf_q <= (store_w & ~room_w) | (ovf_q & ~(wr_status & i_hwdata[STAT_OVF_BIT]));
    end
  end

  // trigger outputs
  wire [4:0] out_vec = {store_q, conv_q, run_lvl, tick_q, 1'b0};
  logic [1:0] fp_out_q;
  logic [1:0] bp_out_q;
  logic [1:0] bp_oe_n_q;

  for (genvar k = 0; k < 2; k++) begin : g_out
    always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
        fp_out_q[k] <= 1'b0;
        bp_out_q[k] <= 1'b0;
        bp_oe_n_q[k] <= 1'b1;
      end else begin
        fp_out_q[k] <= pick(omap_q[4*k +: 3], out_vec);
        bp_out_q[k] <= pick(omap_q[8 + 4*k +: 3], out_vec);
        bp_oe_n_q[k] <= ~omap_q[OMAP_DRIVE_LSB + k];
      end
    end
  end

  // read mux, sampled in the address phase
  always_comb begin
    case (raddr_w)
      OFS_ID: rdata_w = ID_VALUE;
      OFS_CTRL: rdata_w = 32'(ctrl_q);
      OFS_SRC: rdata_w = {24'h000000, src_q};
      OFS_PRESC: rdata_w = {15'h0000, presc_q};
      OFS_OMAP: rdata_w = {14'h0000, omap_q};
      OFS_INCTL: rdata_w = {24'h000000, fp_lat_q, 2'b00, inctl_q};
      OFS_APA: rdata_w = apa_q;
      OFS_APB: rdata_w = apb_q;
      OFS_FIFO: rdata_w = empty_w ? 32'h0000_0000 : mem_rd;
      OFS_COUNT: rdata_w = 32'(count_w);
      OFS_VALUES: rdata_w = {{2{last_q[13]}}, last_q, {2{cur_q[13]}}, cur_q};
      OFS_STAMP: rdata_w = ts_q;
      OFS_RDATA: rdata_w = mem_rd;
      OFS_RADDR: rdata_w = 32'(rd_ptr_q[FIFO_AW-1:0]);
      OFS_IRQ: rdata_w = {16'h0000, vec_q, 6'h00, irq_en_q, roll_q};
      OFS_STATUS: rdata_w = {29'h00000000, ovf_q, full_w, empty_w};
      default: rdata_w = 32'h0000_0000;
    endcase
  end

  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hreadyout_q;
  assign o_hresp = 1'b0;
  assign o_fp_out = fp_out_q;
  assign o_backplane_trigger_pair = bp_out_q;
  assign o_backplane_trigger_pair_oe_n = bp_oe_n_q;
  assign o_adc_convert = conv_q;
  assign o_irq_n = irq_n_q;
  assign o_irq_vector = irq_vec_q;

endmodule

/* act_core_sva.sv */
/*
  act_core_sva: port-level properties of act_core, attached by bind.
  Assumes the bus master of the bench and a single i_mclk domain with active-low reset.
*/
module act_core_sva
  import act_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [1:0] o_backplane_trigger_pair_oe_n,
  input wire logic o_adc_convert,
  input wire logic o_irq_n,
  input wire logic i_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_go;
  logic wr_go;
  logic [2:0] wr_age_q;
  logic [2:0] wr_age_d;
  assign rd_go = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
  assign wr_go = i_hsel & i_htrans[1] & i_hready & i_hwrite;
  // saturating age of the last write, so pin drive changes can be tied to software
  assign wr_age_d = wr_go ? 3'h0 : ((wr_age_q == 3'h7) ? wr_age_q : wr_age_q + 3'h1);
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wr_age_q <= 3'h7;
    end else begin
      wr_age_q <= wr_age_d;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_resp_okay; o_hresp == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("slave response not okay");
  property p_ready_up; $past(i_resetn) |-> o_hreadyout; endproperty
  a_ready_up: assert property (p_ready_up) else $error("slave inserted wait state");
  property p_rdata_idle; !rd_go |=> o_hrdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  property p_id_read; rd_go && i_haddr[7:2] == OFS_ID[7:2] |=> o_hrdata == ID_VALUE; endproperty
  a_id_read: assert property (p_id_read) else $error("identity word wrong");
  property p_presc_range;
    rd_go && i_haddr[7:2] == OFS_PRESC[7:2] |=> o_hrdata >= 32'h1 && o_hrdata <= 32'h186a0;
  endproperty
  a_presc_range: assert property (p_presc_range) else $error("divider out of range");
  property p_irq_release; i_irq_ack |=> ##1 o_irq_n; endproperty
  a_irq_release: assert property (p_irq_release) else $error("request held after acknowledge");
  property p_convert_pulse; o_adc_convert |=> !o_adc_convert; endproperty
  a_convert_pulse: assert property (p_convert_pulse) else $error("convert longer than one cycle");
  property p_oe_by_write; !$stable(o_backplane_trigger_pair_oe_n) |-> wr_age_q <= 3'h3; endproperty
  a_oe_by_write: assert property (p_oe_by_write) else $error("trigger drive changed unasked");
endmodule

bind act_core act_core_sva u_sva (
  .i_mclk(i_mclk),
  .i_resetn(i_resetn),
  .i_hsel(i_hsel),
  .i_haddr(i_haddr),
  .i_htrans(i_htrans),
  .i_hwrite(i_hwrite),
  .i_hready(i_hready),
  .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp),
  .o_backplane_trigger_pair_oe_n(o_backplane_trigger_pair_oe_n),
  .o_adc_convert(o_adc_convert),
  .o_irq_n(o_irq_n),
  .i_irq_ack(i_irq_ack)
);

/* act_host.sv */
/*
  act_host: carrier host model, an AHB-Lite single-word master plus interrupt acknowledge.
  Assumes one slave whose hreadyout is fed back as i_hready.
*/
module act_host (
  input wire logic i_mclk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata,
  output logic o_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
    o_irq_ack = 1'b0;
  end
  // one transfer; an idle cycle always precedes the next address phase
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_mclk);
    o_hsel <= 1'b1;
    o_haddr <= {24'h0, a};
    o_htrans <= 2'h2;
    o_hwrite <= wr;
    @(posedge i_mclk);
    while (!i_hready) @(posedge i_mclk);
    o_htrans <= 2'h0;
    o_hsel <= 1'b0;
    o_hwdata <= wd;
    @(posedge i_mclk);
    while (!i_hready) @(posedge i_mclk);
    rd = i_hrdata;
  endtask
  task ack();
    @(posedge i_mclk);
    o_irq_ack <= 1'b1;
    @(posedge i_mclk);
    o_irq_ack <= 1'b0;
  endtask
endmodule

/* act_pkg.sv */
/*
  act_pkg: shared constants and types of the aperture capture timing core.
  Assumes a single 125 MHz system clock; all offsets are byte addresses on a 32-bit AHB-Lite bus.
*/
package act_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_PRESC = 8'h0c;
  localparam logic [7:0] OFS_OMAP = 8'h10;
  localparam logic [7:0] OFS_INCTL = 8'h14;
  localparam logic [7:0] OFS_APA = 8'h18;
  localparam logic [7:0] OFS_APB = 8'h1c;
  localparam logic [7:0] OFS_FIFO = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  localparam logic [7:0] OFS_VALUES = 8'h28;
  localparam logic [7:0] OFS_STAMP = 8'h2c;
  localparam logic [7:0] OFS_RDATA = 8'h30;
  localparam logic [7:0] OFS_RADDR = 8'h34;
  localparam logic [7:0] OFS_IRQ = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;

  // identity word, value arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0000_5a3c;

  // storage depth in 32-bit words (2**26 = 64M values, 32M pairs)
  localparam int FIFO_AW_DEF = 26;

  // prescaler limits and reset values
  localparam int PRESC_W = 17;
  localparam logic [16:0] PRESC_MIN = 17'h00001;
  localparam logic [16:0] PRESC_MAX = 17'h186a0;
  localparam logic [16:0] PRESC_RST = 17'h00001;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [17:0] OMAP_RST = 18'h00000;
  localparam logic [3:0] INCTL_RST = 4'h0;
  localparam logic [31:0] AP_RST = 32'h0000_0000;
  localparam logic [7:0] VEC_RST = 8'h00;

  // field positions
  localparam int INCTL_REARM_LSB = 4;
  localparam int INCTL_LAT_LSB = 6;
  localparam int OMAP_DRIVE_LSB = 16;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int IRQ_VEC_LSB = 8;
  localparam int STAT_OVF_BIT = 2;

  // signal sources: index into the source vector
  localparam logic [2:0] SRC_INT = 3'h0;
  localparam logic [2:0] SRC_FPA = 3'h1;
  localparam logic [2:0] SRC_FPB = 3'h2;
  localparam logic [2:0] SRC_BPA = 3'h3;
  localparam logic [2:0] SRC_BPB = 3'h4;

  // output selects: index into the output vector
  localparam logic [2:0] OSEL_LOW = 3'h0;
  localparam logic [2:0] OSEL_SCLK = 3'h1;
  localparam logic [2:0] OSEL_RUN = 3'h2;
  localparam logic [2:0] OSEL_CONV = 3'h3;
  localparam logic [2:0] OSEL_STORE = 3'h4;

  // aperture modes
  localparam logic [1:0] AP_OFF = 2'h0;
  localparam logic [1:0] AP_A = 2'h1;
  localparam logic [1:0] AP_EXT = 2'h2;
  localparam logic [1:0] AP_AUTO = 2'h3;

  typedef struct packed {
    logic [22:0] rsvd;
    logic [1:0] ap_mode;
    logic fifo_rst;
    logic ts_clr;
    logic ts_clr_on_en;
    logic ts_free;
    logic pair;
    logic ace;
    logic run;
  } act_ctrl_s;

  localparam act_ctrl_s CTRL_RST = '0;

  typedef struct packed {
    logic [15:0] value;
    logic [31:0] stamp;
  } act_entry_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_SECOND = 2'b10
  } act_wr_e;

endpackage

/* aperture_capture_timing_core_tb.sv */
/*
  aperture_capture_timing_core_tb: register-level tests of act_core through act_host.
  Assumes a converter answering each convert pulse one cycle later; base clock sped up.
*/
module aperture_capture_timing_core_tb
  import act_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_resetn = 1'b0, i_osc_1mhz = 1'b0, i_aperture_sel = 1'b0;
  logic i_adc_done = 1'b0;
  logic [13:0] i_adc_data = 14'h0, adc_val = 14'h0;
  logic [1:0] i_fp_in = 2'h0, o_fp_out, bp_out, bp_oe_n, bp_wire;
  logic hsel, hwrite, hready, hresp, adc_convert, irq_n, irq_ack;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize, osc_cnt = 3'h0;
  logic [7:0] irq_vec;
  int err_total = 0, check_count = 0, cyc = 0;
  logic [31:0] pw[4] = '{32'h0, 32'h30d40, 32'h3, 32'h186a0};
  logic [31:0] pe[4] = '{32'h1, 32'h186a0, 32'h3, 32'h186a0};
  logic [13:0] av[5] = '{14'd100, 14'd105, 14'd120, 14'd115, 14'd105};
  logic [15:0] ae[3] = '{16'd100, 16'd120, 16'd105};

  // a released backplane line is pulled high
  assign bp_wire = (~bp_oe_n & bp_out) | bp_oe_n;

  act_core #(.FIFO_AW(6)) uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_osc_1mhz(i_osc_1mhz),
    .i_fp_in(i_fp_in), .o_fp_out(o_fp_out), .i_backplane_trigger_pair(bp_wire),
    .o_backplane_trigger_pair(bp_out), .o_backplane_trigger_pair_oe_n(bp_oe_n),
    .i_aperture_sel(i_aperture_sel), .o_adc_convert(adc_convert), .i_adc_done(i_adc_done),
    .i_adc_data(i_adc_data), .o_irq_n(irq_n), .i_irq_ack(irq_ack), .o_irq_vector(irq_vec));
  act_host u_host (.i_mclk(i_mclk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
    .o_irq_ack(irq_ack));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // base clock at one eighth of i_mclk keeps the run short
  always @(posedge i_mclk) begin
    osc_cnt <= osc_cnt + 3'h1;
    i_osc_1mhz <= osc_cnt[2];
    i_adc_done <= adc_convert;
    i_adc_data <= adc_val;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      final_report();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    u_host.xfer(1'b1, a, v, rdv);
  endtask
  task rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, rdv);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rdv, exp);
  endtask
  task fp_pulse(input int i);
    @(posedge i_mclk);
    i_fp_in[i] <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_fp_in[i] <= 1'b0;
    repeat (8) @(posedge i_mclk);
  endtask
  task sample(input logic [13:0] v);
    adc_val = v;
    fp_pulse(1);
  endtask
  task final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rdc(OFS_ID, ID_VALUE);
    rdc(OFS_PRESC, 32'(PRESC_RST));
    rdc(8'h40, 32'h0);
    rdc(OFS_STATUS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_PRESC, pw[k]);
      rdc(OFS_PRESC, pe[k]);
    end
    wr(OFS_PRESC, 32'h1);
    wr(OFS_CTRL, 32'h9);
    repeat (80) @(posedge i_mclk);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STAMP);
    check(32'(rdv >= 32'd9 && rdv <= 32'd12), 32'h1);
    wr(OFS_CTRL, 32'h20);
    rdc(OFS_STAMP, 32'h0);
    wr(OFS_SRC, 32'h1);
    wr(OFS_CTRL, 32'h9);
    repeat (5) fp_pulse(0);
    rdc(OFS_STAMP, 32'h5);
    wr(OFS_SRC, 32'h10);
    wr(OFS_OMAP, 32'h10202);
    @(posedge i_mclk);
    i_fp_in[0] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    check(32'(o_fp_out[0]), 32'h1);
    check(32'({bp_oe_n, bp_out[0]}), 32'h5);
    wr(OFS_INCTL, 32'h1);
    repeat (4) @(posedge i_mclk);
    check(32'(o_fp_out[0]), 32'h0);
    wr(OFS_INCTL, 32'h4);
    rd(OFS_INCTL);
    check(32'(rdv[6]), 32'h1);
    i_fp_in[0] <= 1'b0;
    wr(OFS_INCTL, 32'h14);
    rd(OFS_INCTL);
    check(32'(rdv[6]), 32'h0);
    wr(OFS_OMAP, 32'h0);
    wr(OFS_SRC, 32'h2);
    wr(OFS_CTRL, 32'h60);
    wr(OFS_CTRL, 32'h7);
    sample(14'h3ffb);
    sample(14'h0100);
    rdc(OFS_COUNT, 32'h4);
    rdc(OFS_FIFO, 32'hfffb_0000);
    rdc(OFS_FIFO, 32'h0001_0000);
    rdc(OFS_FIFO, 32'h0100_0000);
    rdc(OFS_FIFO, 32'h0002_0000);
    rdc(OFS_FIFO, 32'h0);
    wr(OFS_RADDR, 32'h1);
    rdc(OFS_RADDR, 32'h1);
    rdc(OFS_RDATA, 32'h0001_0000);
    rdc(OFS_COUNT, 32'h3);
    wr(OFS_CTRL, 32'h60);
    wr(OFS_APA, 32'h000a_000a);
    wr(OFS_CTRL, 32'h83);
    for (int k = 0; k < 5; k++) sample(av[k]);
    rdc(OFS_COUNT, 32'h3);
    for (int k = 0; k < 3; k++) rdc(OFS_FIFO, {ae[k], 16'h0});
    i_aperture_sel <= 1'b1;
    wr(OFS_CTRL, 32'h40);
    wr(OFS_CTRL, 32'h103);
    sample(14'd105);
    sample(14'd105);
    sample(14'd106);
    rdc(OFS_COUNT, 32'h2);
    wr(OFS_CTRL, 32'h40);
    wr(OFS_CTRL, 32'h183);
    sample(14'd100);
    sample(14'd100);
    sample(14'd101);
    sample(14'd105);
    rdc(OFS_COUNT, 32'h2);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h12);
    rdc(OFS_STAMP, 32'h0);
    wr(OFS_IRQ, 32'h0000_a502);
    rdc(OFS_IRQ, 32'h0000_a502);
    check(32'(irq_vec), 32'ha5);
    u_host.ack();
    repeat (2) @(posedge i_mclk);
    check(32'(irq_n), 32'h1);
    final_report();
  end
endmodule
